// [hdr_exposure_companding.sv]
`timescale 1ns/100ps
`default_nettype none
`include "hdr_params.svh"

module hdr_exposure_companding #(
  parameter int LINE_W     = 1280,
  parameter int FRAME_MARG = 16'h0034
) (
  // Clock and reset
  input  wire logic                wb_clk_i,
  input  wire logic                rstn,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Row timing
  input  wire logic                rowTick,
  output logic                     ptrValid,
  output logic                     ptrShort,
  output hdr_pkg::row_ptr_t        rowPtr,
  output logic      [15:0]         fineExposure,
  output logic                     motionEnable,
  // Pixel input
  input  wire logic                pixValid,
  output logic                     pixReady,
  input  wire hdr_pkg::pixel_in_t  pixIn,
  // Pixel output
  output logic                     outValid,
  input  wire logic                outReady,
  output logic      [15:0]         outPix
);

  localparam int LW = $clog2(51);
  localparam int CW = $clog2(LINE_W);

  // ----------------------------------------
  // Whole module state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0]   ctrl;      // Mode, companding, ratio
    logic [15:0]   motion;    // Ghost correction control
    logic [15:0]   coarse;    // Programmed coarse exposure
    logic [15:0]   fine;      // Programmed fine exposure
    logic [15:0]   frameLen;  // Frame length in lines
    logic          ack;       // Bus answer
    logic [31:0]   rdat;      // Bus read data
    logic [15:0]   readRow;   // Rolling read row
    logic          phase;     // Short pair follows long pair
    logic [LW-1:0] wrLine;    // Line buffer fill slot
    logic [CW-1:0] wrCol;
    logic [LW-1:0] rdLine;    // Line buffer drain slot
    logic [CW-1:0] rdCol;
  } state_t;

  state_t st_q, st_d;

  // Decoded controls
  logic                hdrMode;      // HDR versus linear
  logic                compEn;       // Companding on
  hdr_pkg::ratio_sel_t ratioSel;     // Programmed ratio
  logic [5:0]          ratioMult;    // Ratio as a number
  logic [15:0]         bufLimit;     // 51 times ratio
  logic [15:0]         minExp;       // Shortest legal long exposure
  logic [15:0]         marginMax;    // Frame bound
  logic [15:0]         longExp;      // Clamped long exposure
  logic [15:0]         shortExp;     // Short exposure in lines
  logic [15:0]         effRatio;     // Ratio used by the merge
  logic [15:0]         maxCoarse;    // Reported limit
  logic [31:0]         recipProd;    // Division by 51 via reciprocal
  // Datapath
  logic [11:0]         longPix;      // Parked long sample
  logic [27:0]         scaled;       // Short times ratio
  logic [28:0]         shifted;      // Pre-shifted into 16 bits
  logic [15:0]         merged;       // Linear 16-bit result
  logic [15:0]         companded;    // 12-bit curve result
  logic [15:0]         wrWord;       // Word entering the buffer
  logic [15:0]         diff;         // Long versus short mismatch
  logic                fifoReady;
  logic                fifoPush;
  logic                shortTake;
  logic                longTake;

  // ----------------------------------------
  // Control decode
  // ----------------------------------------
  assign hdrMode   = st_q.ctrl[`CTRL_HDR_BIT];
  assign compEn    = st_q.ctrl[`CTRL_COMP_BIT];
  assign ratioSel  = hdr_pkg::ratio_sel_t'(st_q.ctrl[`CTRL_RATIO_LSB +: 2]);
  assign ratioMult = 6'h04 << ratioSel;
  assign bufLimit  = `LINE_BUFS << (3'(ratioSel) + 3'd2);

  // ----------------------------------------
  // Exposure limits
  // ----------------------------------------
  always_comb begin
    // Minimum: one row linear, half the ratio in HDR
    minExp    = hdrMode ? 16'(ratioMult >> 1) : 16'h0001;
    marginMax = hdrMode ? st_q.frameLen - 16'(FRAME_MARG)
                        : st_q.frameLen - `LIN_MARGIN;
    longExp   = st_q.coarse;
    if (longExp > marginMax) begin
      longExp = marginMax;
    end
    if (longExp < minExp) begin
      longExp = minExp;
    end
    // Report the combined bound for software
    maxCoarse = (bufLimit < marginMax) ? bufLimit : marginMax;
    // Past the buffer limit the short side stays at 51 lines
    recipProd = 32'(longExp) * `RECIP_51 + `RECIP_51;
    if (longExp > bufLimit) begin
      shortExp = `LINE_BUFS;
      effRatio = recipProd[31:16];
    end else begin
      shortExp = longExp >> (3'(ratioSel) + 3'd2);
      effRatio = 16'(ratioMult);
    end
  end

  // Sub-line exposure has no meaning in HDR
  assign fineExposure = hdrMode ? 16'h0000 : st_q.fine;
  assign motionEnable = st_q.motion[`MOTION_EN_BIT];

  // ----------------------------------------
  // Row pointers, long pair then short pair
  // ----------------------------------------
  function automatic logic [15:0] wrapRow(input logic [15:0] a, input logic [15:0] len);
    logic [16:0] s;
    s = {1'b0, a};
    if (s >= {1'b0, len}) begin
      s = s - {1'b0, len};
    end
    return s[15:0];
  endfunction

  always_comb begin
    ptrValid = rowTick || st_q.phase;
    ptrShort = st_q.phase;
    if (st_q.phase) begin
      // Short reset trails the long read, short read follows it
      rowPtr.readRow  = wrapRow(st_q.readRow + st_q.frameLen - shortExp, st_q.frameLen);
      rowPtr.resetRow = st_q.readRow;
    end else begin
      rowPtr.readRow  = st_q.readRow;
      rowPtr.resetRow = wrapRow(st_q.readRow + longExp, st_q.frameLen);
    end
  end

  // ----------------------------------------
  // Merge and compand
  // ----------------------------------------
  hdr_line_store #(
    .DATA_W (12),
    .LINES  (51),
    .WIDTH  (LINE_W)
  ) u_store (
    .clk    (wb_clk_i),
    .wrEn   (longTake),
    .wrLine (st_q.wrLine),
    .wrCol  (st_q.wrCol),
    .wrData (pixIn.data),
    .rdLine (st_q.rdLine),
    .rdCol  (st_q.rdCol),
    .rdData (longPix)
  );

  // Long samples never stall in HDR; all other samples wait for buffer room
  assign longTake  = pixValid && hdrMode && pixIn.isLong;
  assign shortTake = pixValid && fifoReady && (!hdrMode || !pixIn.isLong);
  assign pixReady  = (hdrMode && pixIn.isLong) || fifoReady;
  assign fifoPush  = shortTake;

  always_comb begin
    scaled = 28'(pixIn.data) * 28'(effRatio);
    // Bring every ratio into a 16-bit range
    unique case (ratioSel)
      hdr_pkg::RATIO_4X:  shifted = {1'b0, scaled} << 2;
      hdr_pkg::RATIO_8X:  shifted = {1'b0, scaled} << 1;
      hdr_pkg::RATIO_16X: shifted = {1'b0, scaled};
      hdr_pkg::RATIO_32X: shifted = {1'b0, scaled} >> 1;
    endcase
    diff = (shifted[15:0] > 16'(longPix)) ? shifted[15:0] - 16'(longPix)
                                          : 16'(longPix) - shifted[15:0];
    // Long sample is used until it saturates
    if (!hdrMode) begin
      merged = 16'(pixIn.data);
    end else if (shifted[28:16] != '0) begin
      merged = 16'hFFFF;
    end else if (longPix >= `LONG_SAT) begin
      merged = shifted[15:0];
    end else if (motionEnable && diff > `MOTION_TOL) begin
      // A moving edge disagrees between exposures; trust the short one
      merged = shifted[15:0];
    end else begin
      merged = 16'(longPix);
    end
    // Fixed four-segment curve, identical for all ratios
    if (merged < `KNEE_P1) begin
      companded = merged;
    end else if (merged < `KNEE_P2) begin
      companded = `KNEE_OUT2 + ((merged - `KNEE_P1) >> 1);
    end else if (merged < `KNEE_P3) begin
      companded = `KNEE_OUT3 + ((merged - `KNEE_P2) >> 5);
    end else begin
      companded = `KNEE_OUT4 + ((merged - `KNEE_P3) >> 6);
    end
    wrWord = compEn ? companded : merged;
  end

  hdr_skid_fifo #(
    .WIDTH (16),
    .DEPTH (2)
  ) u_out (
    .clk      (wb_clk_i),
    .rstn     (rstn),
    .inValid  (fifoPush),
    .inReady  (fifoReady),
    .inData   (wrWord),
    .outValid (outValid),
    .outReady (outReady),
    .outData  (outPix)
  );

  // ----------------------------------------
  // Next state: bus, counters
  // ----------------------------------------
  always_comb begin
    logic [15:0] wmask;
    wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    st_d = st_q;
    st_d.ack = wb_cyc_i && wb_stb_i && !st_q.ack;
    if (st_d.ack) begin
      // Unmapped offsets read zero and ignore writes
      unique case (wb_adr_i)
        `OFS_CTRL:       st_d.rdat = {16'h0000, st_q.ctrl};
        `OFS_MOTION:     st_d.rdat = {16'h0000, st_q.motion};
        `OFS_COARSE:     st_d.rdat = {16'h0000, st_q.coarse};
        `OFS_FINE:       st_d.rdat = {16'h0000, st_q.fine};
        `OFS_FRAME_LEN:  st_d.rdat = {16'h0000, st_q.frameLen};
        `OFS_EXPO_STAT:  st_d.rdat = {maxCoarse, longExp};
        `OFS_RATIO_STAT: st_d.rdat = {effRatio, shortExp};
        default:         st_d.rdat = 32'h0000_0000;
      endcase
      if (wb_we_i) begin
        unique case (wb_adr_i)
          `OFS_CTRL:      st_d.ctrl     = ((st_q.ctrl & ~wmask) | (wb_dat_i[15:0] & wmask)) & 16'h000F;
          `OFS_MOTION:    st_d.motion   = (st_q.motion & ~wmask) | (wb_dat_i[15:0] & wmask);
          `OFS_COARSE:    st_d.coarse   = (st_q.coarse & ~wmask) | (wb_dat_i[15:0] & wmask);
          `OFS_FINE:      st_d.fine     = (st_q.fine & ~wmask) | (wb_dat_i[15:0] & wmask);
          `OFS_FRAME_LEN: st_d.frameLen = (st_q.frameLen & ~wmask) | (wb_dat_i[15:0] & wmask);
          default: ;
        endcase
      end
    end
    // Row sequencer
    st_d.phase = rowTick;
    if (rowTick) begin
      st_d.readRow = wrapRow(st_q.readRow + 16'h0001, st_q.frameLen);
    end
    // Line buffer slots wrap over the 51 lines
    if (longTake) begin
      st_d.wrCol = pixIn.eol ? '0 : st_q.wrCol + 1'b1;
      if (pixIn.eol) begin
        st_d.wrLine = (st_q.wrLine == LW'(50)) ? '0 : st_q.wrLine + 1'b1;
      end
    end
    if (shortTake && hdrMode) begin
      st_d.rdCol = pixIn.eol ? '0 : st_q.rdCol + 1'b1;
      if (pixIn.eol) begin
        st_d.rdLine = (st_q.rdLine == LW'(50)) ? '0 : st_q.rdLine + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge wb_clk_i) begin
    if (!rstn) begin
      st_q          <= '0;
      st_q.ctrl     <= `RST_CTRL;
      st_q.motion   <= `RST_MOTION;
      st_q.coarse   <= `RST_COARSE;
      st_q.fine     <= `RST_FINE;
      st_q.frameLen <= `RST_FRAME_LEN;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = st_q.rdat;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence longIssue;
    ptrValid && !ptrShort;
  endsequence
  sequence shortIssue;
    ptrValid && ptrShort;
  endsequence

  chk_hdr_default: assert property (@(posedge wb_clk_i) disable iff (!rstn)
    $past(rstn) == 1'b0 |-> hdrMode) else $error("not in HDR after reset");
  chk_ptr_pairs: assert property (@(posedge wb_clk_i) disable iff (!rstn)
    longIssue ##0 rowTick |=> shortIssue) else $error("short pair missing");
  chk_merge_push: assert property (@(posedge wb_clk_i) disable iff (!rstn)
    pixValid && pixReady && hdrMode && !pixIn.isLong |-> fifoPush && !longTake) else $error("merge lost");
  chk_comp_width: assert property (@(posedge wb_clk_i) disable iff (!rstn)
    fifoPush && compEn |-> wrWord < 16'h0F80) else $error("companded above 12 bits");
  chk_knee_value: assert property (@(posedge wb_clk_i) disable iff (!rstn)
    fifoPush && compEn && merged == `KNEE_P2 |-> wrWord == `KNEE_OUT3) else $error("knee wrong");
  chk_ratio_field: assert property (@(posedge wb_clk_i) disable iff (!rstn)
    st_q.ctrl[3:2] == 2'b10 |-> ratioMult == 6'h10) else $error("ratio decode wrong");
  chk_short_limit: assert property (@(posedge wb_clk_i) disable iff (!rstn)
    hdrMode && longExp > bufLimit |-> shortExp == `LINE_BUFS) else $error("short not held");
  chk_frame_margin: assert property (@(posedge wb_clk_i) disable iff (!rstn)
    hdrMode && st_q.frameLen >= 16'h0100 |-> longExp <= st_q.frameLen - 16'(FRAME_MARG))
    else $error("long exposure over margin");
  chk_fine_ignored: assert property (@(posedge wb_clk_i) disable iff (!rstn)
    hdrMode |-> fineExposure == 16'h0000) else $error("fine used in HDR");
  chk_min_expo: assert property (@(posedge wb_clk_i) disable iff (!rstn)
    hdrMode |-> longExp >= 16'(ratioMult >> 1)) else $error("exposure below minimum");
  chk_bus_ack: assert property (@(posedge wb_clk_i) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

endmodule

`default_nettype wire

// [hdr_exposure_companding_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "hdr_params.svh"

module hdr_exposure_companding_tb_top;
  // ----------------------------------------
  // Bench signals
  // ----------------------------------------
  logic               clk = 1'b0;
  logic               rstn = 1'b0;
  logic               wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0]         wbAdr = 8'h00;
  logic [31:0]        wbDatW = 32'h0000_0000, wbDatR;
  logic               wbAck, rowTick = 1'b0, ptrValid, ptrShort, motionEnable;
  hdr_pkg::row_ptr_t  rowPtr;
  logic [15:0]        fineExposure, outPix;
  logic               pixValid = 1'b0, pixReady, outValid, outReady;
  hdr_pkg::pixel_in_t pixIn = '0;
  logic [1:0]         ratioSel = 2'd2;  // Programmed ratio, for the receiver
  logic               compOn = 1'b0, hold = 1'b0;
  logic [15:0]        expQ[$];          // Words the receiver should see
  int                 error_cnt = 0, checks = 0;

  // 25 ns period
  always #12.5 clk = ~clk;

  hdr_exposure_companding #(.LINE_W(8)) DUT (
    .wb_clk_i(clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'h3), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .rowTick(rowTick), .ptrValid(ptrValid), .ptrShort(ptrShort), .rowPtr(rowPtr),
    .fineExposure(fineExposure), .motionEnable(motionEnable), .pixValid(pixValid),
    .pixReady(pixReady), .pixIn(pixIn), .outValid(outValid), .outReady(outReady), .outPix(outPix));

  hdr_relin_sink sink (
    .clk(clk), .rstn(rstn), .outValid(outValid), .outReady(outReady), .outPix(outPix),
    .ratioSel(ratioSel), .compOn(compOn), .hold(hold));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // A wait that ran out ends the run
  task automatic timeout();
    error_cnt++;
    close_out();
  endtask

  // Knee curve worked out from the segment ends
  function automatic logic [15:0] comp(input logic [15:0] x);
    if (x < 16'h0400) return x;
    if (x < 16'h1000) return 16'((x - 16'h0400) / 2 + 16'h0400);
    if (x < 16'h8000) return 16'((x - 16'h1000) / 32 + 16'h0A00);
    return 16'((x - 16'h8000) / 64 + 16'h0D80);
  endfunction

  // ----------------------------------------
  // Bus and stream drivers
  // ----------------------------------------
  // Classic cycle; ack and read data are taken at the edge that samples ack high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    logic r;
    int   n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a; wbDatW <= d;
    do begin
      @(posedge clk);
      r = wbAck;
      q = wbDatR;
      n++;
    end while (!r && n < 50);
    if (!r) timeout();
    wbCyc <= 1'b0; wbStb <= 1'b0;
  endtask

  task automatic ctrl(input logic [3:0] v);
    logic [31:0] q;
    wb(1'b1, `OFS_CTRL, {28'h000_0000, v}, q);
    ratioSel = v[3:2];
    compOn = v[1];
  endtask

  task automatic send(input logic lng, input logic eol, input logic [11:0] d);
    logic r;
    int   n;
    n = 0;
    @(posedge clk);
    pixValid <= 1'b1;
    pixIn <= {lng, eol, d};
    do begin
      @(negedge clk);
      r = pixReady;
      @(posedge clk);
      n++;
    end while (!r && n < 200);
    if (!r) timeout();
    pixValid <= 1'b0;
  endtask

  // Eight pixels with a saturated long line and corner shorts
  task automatic line(input logic lng, input logic hdr);
    logic [11:0] d;
    logic [15:0] m;
    for (int k = 0; k < 8; k++) begin
      d = lng ? 12'hFFF : (k == 0) ? 12'hFFF : (k == 1) ? 12'h040 : (k == 2) ? 12'h100 : 12'($urandom);
      m = hdr ? {d, 4'h0} : {4'h0, d};
      if (!lng) expQ.push_back(compOn ? comp(m) : m);
      send(lng, k == 7, d);
    end
  endtask

  task automatic drain(input int mul);
    int n;
    n = 0;
    while (sink.got.size() < expQ.size() && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n == 3000) timeout();
    foreach (expQ[i]) chk({16'h0000, sink.got[i]}, {16'h0000, expQ[i]});
    // Lossless knee corners come back as the short sample times the programmed ratio
    if (mul != 0) begin
      chk(32'(sink.relin[1]), 32'(mul * 32'h40));
      chk(32'(sink.relin[2]), 32'(mul * 32'h100));
    end
    sink.got.delete();
    sink.relin.delete();
    expQ.delete();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    void'($urandom(32'h7d68));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b0, `OFS_CTRL, 32'h0000_0000, q); chk(q, 32'h0000_0009);
    wb(1'b0, 8'hFC, 32'h0000_0000, q); chk(q, 32'h0000_0000);
    wb(1'b1, `OFS_MOTION, 32'h0000_4000, q);
    @(negedge clk); chk(motionEnable, 1'b1);
    wb(1'b1, `OFS_MOTION, 32'h0000_0000, q);
    wb(1'b1, `OFS_FINE, 32'h0000_0055, q);
    @(negedge clk); chk(fineExposure, 16'h0000);
    wb(1'b1, `OFS_COARSE, 32'h0000_03CC, q);
    wb(1'b0, `OFS_EXPO_STAT, 32'h0000_0000, q); chk(q, 32'h0330_03CC);
    wb(1'b0, `OFS_RATIO_STAT, 32'h0000_0000, q); chk(q, 32'h0013_0033);
    wb(1'b1, `OFS_COARSE, 32'h0000_0001, q);
    wb(1'b0, `OFS_EXPO_STAT, 32'h0000_0000, q); chk(q, 32'h0330_0008);
    // Long pair first, then short pair in the next cycle
    @(posedge clk) rowTick <= 1'b1;
    @(negedge clk); chk({ptrValid, ptrShort}, 2'b10);
    chk(16'(rowPtr.resetRow - rowPtr.readRow), 16'h0008);
    @(posedge clk) rowTick <= 1'b0;
    @(negedge clk); chk({ptrValid, ptrShort}, 2'b11);
    ctrl(4'hA);
    @(negedge clk); chk(fineExposure, 16'h0055);
    line(1'b0, 1'b0); drain(0);
    ctrl(4'h8);
    // Receiver stalls until the buffer refuses, then drains it
    hold <= 1'b1;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 2; k++) send(1'b0, 1'b0, 12'h123);
    @(posedge clk) pixValid <= 1'b1;
    repeat (3) @(negedge clk);
    chk(pixReady, 1'b0);
    hold = 1'b0;
    send(1'b0, 1'b0, 12'h123);
    repeat (3) expQ.push_back(16'h0123);
    line(1'b0, 1'b0); drain(0);
    // Every ratio lands in the same 16-bit range and curve
    for (int r = 0; r < 4; r++) begin
      ctrl(4'(4'h3 | (r << 2)));
      line(1'b1, 1'b1);
      line(1'b0, 1'b1); drain(4 << r);
    end
    close_out();
  end
endmodule

`default_nettype wire

// [hdr_line_store.sv]
`timescale 1ns/100ps
`default_nettype none

module hdr_line_store #(
  parameter int DATA_W = 12,
  parameter int LINES  = 51,
  parameter int WIDTH  = 1280
) (
  // Clock
  input  wire logic                      clk,
  // Write port
  input  wire logic                      wrEn,
  input  wire logic [$clog2(LINES)-1:0]  wrLine,
  input  wire logic [$clog2(WIDTH)-1:0]  wrCol,
  input  wire logic [DATA_W-1:0]         wrData,
  // Read port
  input  wire logic [$clog2(LINES)-1:0]  rdLine,
  input  wire logic [$clog2(WIDTH)-1:0]  rdCol,
  output logic      [DATA_W-1:0]         rdData
);

  // Long samples parked until their short partner arrives
  logic [DATA_W-1:0] mem [LINES][WIDTH];

  // ----------------------------------------
  // Write
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrLine][wrCol] <= wrData;
    end
  end

  // Read is combinational so the merge needs no extra stage
  assign rdData = mem[rdLine][rdCol];

endmodule

`default_nettype wire

// [hdr_params.svh]
`ifndef HDR_PARAMS_SVH
`define HDR_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL        8'h00
`define OFS_MOTION      8'h04
`define OFS_COARSE      8'h08
`define OFS_FINE        8'h0C
`define OFS_FRAME_LEN   8'h10
`define OFS_EXPO_STAT   8'h14
`define OFS_RATIO_STAT  8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_HDR_BIT    0
`define CTRL_COMP_BIT   1
`define CTRL_RATIO_LSB  2
`define MOTION_EN_BIT   14

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CTRL        16'h0009
`define RST_MOTION      16'h0000
`define RST_COARSE      16'h0100
`define RST_FINE        16'h0000
`define RST_FRAME_LEN   16'h0400

// ----------------------------------------
// Exposure limits
// ----------------------------------------
`define LINE_BUFS       16'h0033
`define HDR_MARGIN      16'h0034
`define LIN_MARGIN      16'h0001
`define RECIP_51        32'h0000_0505

// ----------------------------------------
// Compander knees and merge thresholds
// ----------------------------------------
`define KNEE_P1         16'h0400
`define KNEE_P2         16'h1000
`define KNEE_P3         16'h8000
`define KNEE_OUT2       16'h0400
`define KNEE_OUT3       16'h0A00
`define KNEE_OUT4       16'h0D80
`define LONG_SAT        12'hF00
`define MOTION_TOL      16'h0100

`endif

// [hdr_pkg.sv]
package hdr_pkg;

  // Exposure ratio field, ascending
  typedef enum logic [1:0] {RATIO_4X, RATIO_8X, RATIO_16X, RATIO_32X} ratio_sel_t;

  // One incoming pixel
  typedef struct packed {
    logic        isLong;  // Long exposure sample
    logic        eol;     // Last pixel of its line
    logic [11:0] data;    // Raw sample
  } pixel_in_t;

  // One row pointer pair
  typedef struct packed {
    logic [15:0] readRow;
    logic [15:0] resetRow;
  } row_ptr_t;

endpackage

// [hdr_relin_sink.sv]
`timescale 1ns/100ps
`default_nettype none

module hdr_relin_sink (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Stream from the block
  input  wire logic        outValid,
  output var  logic        outReady,
  input  wire logic [15:0] outPix,
  // Programmed setup and stall request
  input  wire logic [1:0]  ratioSel,
  input  wire logic        compOn,
  input  wire logic        hold
);
  // ----------------------------------------
  // Receiver state
  // ----------------------------------------
  logic [15:0] got[$];  // Words taken, in order
  logic [17:0] lin;     // Word back on the linear scale
  logic [17:0] relin[$]; // Relinearized pixels, pre-shift undone

  // Inverse of the four-segment knee curve
  function automatic logic [15:0] expand(input logic [15:0] c);
    if (c < 16'h0400) return c;
    if (c < 16'h0A00) return 16'((c - 16'h0400) * 2 + 16'h0400);
    if (c < 16'h0D80) return 16'((c - 16'h0A00) * 32 + 16'h1000);
    return 16'((c - 16'h0D80) * 64 + 16'h8000);
  endfunction

  initial outReady = 1'b0;

  // Random stalls, so the block's buffer really fills
  always @(posedge clk) begin
    outReady <= rstn && !hold && ($urandom % 3 != 0);
    if (rstn && outValid && outReady) begin
      got.push_back(outPix);
      lin = {2'b00, compOn ? expand(outPix) : outPix};
      // Programmed ratio only, whatever the block used inside
      relin.push_back((ratioSel == 2'd3) ? lin << 1 : lin >> (2'd2 - ratioSel));
    end
  end
endmodule

`default_nettype wire

// [hdr_skid_fifo.sv]
`timescale 1ns/100ps
`default_nettype none

module hdr_skid_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  // Whole state of the buffer
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wrPtr;
    logic [PW-1:0]               rdPtr;
    logic [PW:0]                 count;
  } fifo_state_t;

  fifo_state_t st_q, st_d;
  logic        push, pop;

  // Honest flags from the count
  assign inReady  = (st_q.count != (PW+1)'(DEPTH));
  assign outValid = (st_q.count != '0);
  assign outData  = st_q.mem[st_q.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wrPtr] = inData;
      st_d.wrPtr = (st_q.wrPtr == PW'(DEPTH-1)) ? '0 : st_q.wrPtr + 1'b1;
    end
    if (pop) begin
      st_d.rdPtr = (st_q.rdPtr == PW'(DEPTH-1)) ? '0 : st_q.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      st_d.count = st_q.count + 1'b1;
    end else if (pop && !push) begin
      st_d.count = st_q.count - 1'b1;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

`default_nettype wire
